// ### dvs_top.sv
`timescale 1ns/100ps
module dvs_top
    import dvs_pkg::*;
#(
    parameter int NUM_CH = DVS_NUM_CH,
    parameter int WORD_W = DVS_WORD_W
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    // Pixel interface pins
    input  wire logic                     pix_clk_i,
    input  wire logic [WORD_W-1:0]        pixel_word_in_i,
    input  wire logic                     sequence_begin_strobe_i,
    input  wire logic                     start_right_i,
    input  wire logic                     output_transfer_strobe_i,
    // Output mode and protection
    input  wire logic                     polarity_flip_i,
    input  wire logic                     prot_enable_i,
    output logic                          polarity_flip_o,
    output logic                          prot_active_o,
    // Channel outputs, channel 0 in the low bits
    output logic [NUM_CH*WORD_W-1:0]      channel_outputs_o,
    output logic                          loading_o
);
    // Channel index width and first/last channels are fixed for twelve
    generate
        if (NUM_CH != DVS_NUM_CH || WORD_W < 1) begin : g_bad_cfg
            $error("dvs_top: unsupported channel count or word width");
        end
    endgenerate

    // Pins from the controller's domain pass two flops; a third
    // stage gives edge detection without touching the first flop.
    logic [DVS_SYNC_W-1:0] clk_sync_reg;
    logic [DVS_SYNC_W-1:0] start_sync_reg;
    logic [DVS_SYNC_W-1:0] dir_sync_reg;
    logic [DVS_SYNC_W-1:0] xfr_sync_reg;
    logic [1:0]            pol_sync_reg;
    logic [1:0]            prot_sync_reg;
    logic [WORD_W-1:0]     data_s1_reg;
    logic [WORD_W-1:0]     data_s2_reg;
    logic [WORD_W-1:0]     data_s3_reg;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            clk_sync_reg   <= DVS_SYNC_RST;
            start_sync_reg <= DVS_SYNC_RST;
            dir_sync_reg   <= DVS_SYNC_RST;
            xfr_sync_reg   <= DVS_SYNC_RST;
            pol_sync_reg   <= 2'h0;
            prot_sync_reg  <= 2'h0;
            data_s1_reg    <= WORD_W'(DVS_WORD_RST);
            data_s2_reg    <= WORD_W'(DVS_WORD_RST);
            data_s3_reg    <= WORD_W'(DVS_WORD_RST);
        end else begin
            clk_sync_reg   <= {clk_sync_reg[1:0], pix_clk_i};
            start_sync_reg <= {start_sync_reg[1:0], sequence_begin_strobe_i};
            dir_sync_reg   <= {dir_sync_reg[1:0], start_right_i};
            xfr_sync_reg   <= {xfr_sync_reg[1:0], output_transfer_strobe_i};
            pol_sync_reg   <= {pol_sync_reg[0], polarity_flip_i};
            prot_sync_reg  <= {prot_sync_reg[0], prot_enable_i};
            data_s1_reg    <= pixel_word_in_i;
            data_s2_reg    <= data_s1_reg;
            data_s3_reg    <= data_s2_reg;
        end
    end

    // Edges seen on stages 2/3; data and strobes from stage 3 are the
    // values that stood just before the edge, which covers zero setup.
    wire rise_w = clk_sync_reg[1] & ~clk_sync_reg[2];
    wire fall_w = ~clk_sync_reg[1] & clk_sync_reg[2];
    wire edge_w = rise_w | fall_w;

    logic                    start_pend_reg;
    logic                    xfr_pend_reg;
    logic                    dir_reg;
    logic [DVS_CH_IDX_W-1:0] ptr_reg;
    dvs_pass_t               state_reg;
    logic                    pol_reg;
    logic                    prot_reg;
    logic                    loading_reg;
    dvs_pass_t               state_next;
    logic                    dir_next;
    logic [DVS_CH_IDX_W-1:0] ptr_next;
    logic                    loading_next;

    // Pass start wins over any pass still in progress
    wire begin_w = rise_w & start_pend_reg;
    wire dir_now_w = dir_sync_reg[2];
    wire [DVS_CH_IDX_W-1:0] first_w =
        dir_now_w ? DVS_FIRST_RIGHT : DVS_FIRST_LEFT;
    wire [DVS_CH_IDX_W-1:0] last_w =
        dir_reg ? DVS_FIRST_LEFT : DVS_FIRST_RIGHT;
    wire write_w = begin_w | (edge_w & (state_reg == DVS_LOAD));
    wire [DVS_CH_IDX_W-1:0] wr_idx_w = begin_w ? first_w : ptr_reg;
    wire [DVS_CH_IDX_W-1:0] step_up_w = ptr_reg + 4'h1;
    wire [DVS_CH_IDX_W-1:0] step_dn_w = ptr_reg - 4'h1;
    wire [DVS_CH_IDX_W-1:0] step_w = dir_reg ? step_dn_w : step_up_w;
    wire [DVS_CH_IDX_W-1:0] first_next_w =
        dir_now_w ? DVS_FIRST_RIGHT - 4'h1 : DVS_FIRST_LEFT + 4'h1;
    wire xfer_w = rise_w & xfr_pend_reg;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            start_pend_reg <= 1'b0;
            xfr_pend_reg   <= 1'b0;
        end else if (rise_w) begin
            start_pend_reg <= start_sync_reg[2];
            xfr_pend_reg   <= xfr_sync_reg[2];
        end
    end

    // Pass sequencing; a restart mid-pass simply reloads the pointer and direction
    always_comb begin
        state_next = state_reg;
        dir_next   = dir_reg;
        ptr_next   = ptr_reg;
        case (state_reg)
            DVS_IDLE: begin
                if (begin_w) begin
                    state_next = DVS_LOAD;
                    dir_next   = dir_now_w;
                    ptr_next   = first_next_w;
                end
            end
            DVS_LOAD: begin
                if (begin_w) begin
                    dir_next = dir_now_w;
                    ptr_next = first_next_w;
                end else if (edge_w) begin
                    if (ptr_reg == last_w) begin
                        state_next = DVS_IDLE;
                    end else begin
                        ptr_next = step_w;
                    end
                end
            end
            default: begin
                state_next = DVS_IDLE;
            end
        endcase
    end

    // Busy flag gets its own flop so the output is not a decode
    assign loading_next = (state_next == DVS_LOAD);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg   <= DVS_IDLE;
            dir_reg     <= 1'b0;
            ptr_reg     <= DVS_FIRST_LEFT;
            loading_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            dir_reg     <= dir_next;
            ptr_reg     <= ptr_next;
            loading_reg <= loading_next;
        end
    end

    // Mode bits are steady levels, so two flops are enough.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pol_reg  <= 1'b0;
            prot_reg <= 1'b0;
        end else begin
            pol_reg  <= pol_sync_reg[1];
            prot_reg <= prot_sync_reg[1];
        end
    end

    assign polarity_flip_o = pol_reg;
    assign prot_active_o   = prot_reg;
    assign loading_o       = loading_reg;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            wire load_w = write_w & (wr_idx_w == DVS_CH_IDX_W'(ch));
            dvs_chan #(
                .WORD_W (WORD_W)
            ) u_chan (
                .clk_i  (clk_i),
                .rstn_i (rstn_i),
                .load_i (load_w),
                .word_i (data_s3_reg),
                .xfer_i (xfer_w),
                .out_o  (channel_outputs_o[ch*WORD_W +: WORD_W])
            );
        end
    endgenerate
endmodule

// ### dvs_chan.sv
`timescale 1ns/100ps
package dvs_pkg;
    localparam int             DVS_CLK_PERIOD_NS = 25;
    localparam int             DVS_NUM_CH        = 12;
    localparam int             DVS_WORD_W        = 10;
    localparam int             DVS_CH_IDX_W      = 4;
    localparam int             DVS_SYNC_W        = 3;
    localparam logic [3:0]     DVS_FIRST_LEFT    = 4'h0;
    localparam logic [3:0]     DVS_FIRST_RIGHT   = 4'hB;
    localparam logic [9:0]     DVS_WORD_RST      = 10'h000;
    localparam logic [2:0]     DVS_SYNC_RST      = 3'h0;
    typedef enum logic {DVS_IDLE, DVS_LOAD} dvs_pass_t;
endpackage

// One channel: holding register plus output register
module dvs_chan
    import dvs_pkg::*;
#(
    parameter int WORD_W = DVS_WORD_W
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    // Load and transfer
    input  wire logic              load_i,
    input  wire logic [WORD_W-1:0] word_i,
    input  wire logic              xfer_i,
    // Output value
    output logic      [WORD_W-1:0] out_o
);
    logic [WORD_W-1:0] hold_reg;
    logic [WORD_W-1:0] out_reg;

    assign out_o = out_reg;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            hold_reg <= WORD_W'(DVS_WORD_RST);
            out_reg  <= WORD_W'(DVS_WORD_RST);
        end else begin
            if (load_i) begin
                hold_reg <= word_i;
            end
            // Transfer takes the held value from before any same-cycle load
            if (xfer_i) begin
                out_reg <= hold_reg;
            end
        end
    end
endmodule

// ### dvs_top_asserts.sv
`timescale 1ns/100ps
module dvs_top_asserts
    import dvs_pkg::*;
#(
    parameter int NUM_CH = DVS_NUM_CH,
    parameter int WORD_W = DVS_WORD_W
) (
    // Watched ports
    input wire logic                     clk_i,
    input wire logic                     rstn_i,
    input wire logic                     pix_clk_i,
    input wire logic                     output_transfer_strobe_i,
    input wire logic                     polarity_flip_i,
    input wire logic                     prot_enable_i,
    input wire logic                     polarity_flip_o,
    input wire logic                     prot_active_o,
    input wire logic [NUM_CH*WORD_W-1:0] channel_outputs_o,
    input wire logic                     loading_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    pol_follow_a: assert property (
        polarity_flip_o == $past(polarity_flip_i, 3))
        else $error("polarity lag wrong");
    prot_follow_a: assert property (
        prot_active_o == $past(prot_enable_i, 3))
        else $error("protection state wrong");
    out_edge_a: assert property (
        $changed(channel_outputs_o) |-> $past(pix_clk_i) && $past(pix_clk_i, 2))
        else $error("outputs moved off a rising edge");
    xfr_need_a: assert property (
        $changed(channel_outputs_o) |-> $past(output_transfer_strobe_i, 8))
        else $error("outputs moved without transfer");
    load_start_a: assert property (
        $rose(loading_o) |-> $past(pix_clk_i) && $past(pix_clk_i, 2))
        else $error("pass began off a rising edge");
    load_end_a: assert property (
        $fell(loading_o) |-> !$past(pix_clk_i) && !$past(pix_clk_i, 2))
        else $error("pass ended off a falling edge");
    load_len_a: assert property (
        $rose(loading_o) |-> loading_o [*8])
        else $error("pass too short");
    rst_quiet_a: assert property (
        $rose(rstn_i) |-> channel_outputs_o == '0 && !loading_o)
        else $error("outputs not cleared");
    cover property ($rose(loading_o));
    cover property ($fell(loading_o));
    cover property ($changed(channel_outputs_o));
endmodule
bind dvs_top dvs_top_asserts #(.NUM_CH(NUM_CH), .WORD_W(WORD_W)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .pix_clk_i(pix_clk_i),
    .output_transfer_strobe_i(output_transfer_strobe_i),
    .polarity_flip_i(polarity_flip_i), .prot_enable_i(prot_enable_i),
    .polarity_flip_o(polarity_flip_o), .prot_active_o(prot_active_o),
    .channel_outputs_o(channel_outputs_o), .loading_o(loading_o));

// ### dvs_tcon.sv
`timescale 1ns/100ps
module dvs_tcon
    import dvs_pkg::*;
(
    // Pixel side
    input  wire logic             clk_i,
    output logic                  pix_clk_o,
    output logic [DVS_WORD_W-1:0] word_o,
    output logic                  begin_o,
    output logic                  xfer_o
);
    // Pixel clock stands still outside frames
    initial {pix_clk_o, word_o, begin_o, xfer_o} = '0;
    // Word and strobes stand 4 clk around each pixel edge
    task automatic edge_t(input logic [DVS_WORD_W-1:0] w,
                          input logic st, input logic xf);
        @(posedge clk_i);
        #2;
        word_o = w;
        begin_o = st;
        xfer_o = xf;
        @(posedge clk_i);
        #2;
        pix_clk_o = ~pix_clk_o;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module testbench
    import dvs_pkg::*;
;
    localparam int OW = DVS_NUM_CH * DVS_WORD_W;
    logic                  clk_i = 1'h0;
    logic                  rstn_i = 1'h0;
    logic                  dir_r = 1'h0;
    logic                  pol = 1'h0;
    logic                  prot = 1'h0;
    logic                  pix_clk, st, xf, pol_o, prot_o, loading;
    logic [DVS_WORD_W-1:0] word;
    logic [OW-1:0]         outs, exp_outs, exp_hold;
    int                    err_count = 0;
    int                    comparisons = 0;
    always #12.5 clk_i = ~clk_i;
    dvs_tcon tcon (.clk_i(clk_i), .pix_clk_o(pix_clk), .word_o(word),
                   .begin_o(st), .xfer_o(xf));
    dvs_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .pix_clk_i(pix_clk),
        .pixel_word_in_i(word), .sequence_begin_strobe_i(st),
        .start_right_i(dir_r), .output_transfer_strobe_i(xf),
        .polarity_flip_i(pol), .prot_enable_i(prot),
        .polarity_flip_o(pol_o), .prot_active_o(prot_o),
        .channel_outputs_o(outs), .loading_o(loading));
    // Start, dropped fall, twelve words, then extra words that must drop
    task automatic pass_t(input logic right, input logic [9:0] base,
                          input int extra);
        int ch;
        #2 dir_r = right;
        tcon.edge_t(10'h3FF, 1'h1, 1'h0);
        tcon.edge_t(10'h3FF, 1'h0, 1'h0);
        for (int i = 0; i < DVS_NUM_CH; i++) begin
            ch = right ? DVS_NUM_CH - 1 - i : i;
            exp_hold[ch*DVS_WORD_W +: DVS_WORD_W] = base + DVS_WORD_W'(i);
            tcon.edge_t(base + DVS_WORD_W'(i), 1'h0, 1'h0);
        end
        for (int i = 0; i < extra; i++)
            tcon.edge_t(10'h055, 1'h0, 1'h0);
    endtask
    task automatic xfer_t();
        exp_outs = exp_hold;
        for (int i = 0; i < 4; i++)
            tcon.edge_t(10'h2AA, 1'h0, i < 2);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        #2 rstn_i = 1'h1;
        repeat (4) @(posedge clk_i);
        `CHK(outs, '0)
        pass_t(1'h0, 10'h100, 0);
        `CHK(outs, '0)
        xfer_t();
        `CHK(outs, exp_outs)
        $display("test left pass done");
        pass_t(1'h1, 10'h2A0, 2);
        `CHK(loading, 1'h0)
        `CHK(outs, exp_outs)
        xfer_t();
        `CHK(outs, exp_outs)
        $display("test right pass done");
        for (int v = 1; v >= 0; v--) begin
            #2 pol = v[0];
            prot = v[0];
            repeat (5) @(posedge clk_i);
            `CHK(pol_o, v[0])
            `CHK(prot_o, v[0])
        end
        $display("test mode pins done");
        tally_and_finish();
    end
endmodule
